// ### src/asr_pkg.sv
// Purpose: constants and types of the acceleration sample readout block
// Assumes: one clock, synchronous active-high reset, byte-wide register port
// Notes: offsets are byte addresses on the register port

package asr_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ASR_OFS_X_LOW = 8'h02;
  localparam logic [7:0] ASR_OFS_X_HIGH = 8'h03;
  localparam logic [7:0] ASR_OFS_Y_LOW = 8'h04;
  localparam logic [7:0] ASR_OFS_Y_HIGH = 8'h05;
  localparam logic [7:0] ASR_OFS_Z_LOW = 8'h06;
  localparam logic [7:0] ASR_OFS_Z_HIGH = 8'h07;
  localparam logic [7:0] ASR_OFS_TEMP = 8'h08;
  localparam logic [7:0] ASR_OFS_CTRL = 8'h20;
  localparam logic [7:0] ASR_OFS_INT_STATUS = 8'h21;
  localparam logic [7:0] ASR_OFS_INT_MASK = 8'h22;

  // ==========================================================
  // field positions
  localparam int ASR_CTRL_LOCK_DIS_BIT = 0;
  localparam int ASR_LOW_FRESH_BIT = 0;
  localparam int ASR_LOW_DATA_LSB = 4;
  localparam int ASR_INT_SAMPLE_BIT = 0;
  localparam int ASR_INT_TEMP_BIT = 1;
  localparam int ASR_INT_OVERRUN_BIT = 2;
  localparam int ASR_INT_BITS = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] ASR_CTRL_RESET = 8'h00;
  localparam logic [2:0] ASR_INT_MASK_RESET = 3'h0;
  localparam logic [11:0] ASR_SAMPLE_RESET = 12'h000;
  localparam logic [7:0] ASR_TEMP_RESET = 8'h00;

  // ==========================================================
  // temperature scale: code 0 stands for this many degrees C
  localparam int ASR_TEMP_ZERO_DEGC = 23;
  localparam logic signed [8:0] ASR_TEMP_ZERO_9 = 9'sh017;

  // ==========================================================
  // carriers
  localparam int ASR_AXES = 3;
  localparam int ASR_SAMPLE_W = 12;

  typedef struct packed {
    logic [11:0] z;
    logic [11:0] y;
    logic [11:0] x;
  } asr_sample_t;

  typedef struct packed {
    logic valid;
    logic signed [7:0] degc;
  } asr_temp_t;

endpackage

// ### src/asr_readout.sv
// Purpose: axis sample and die temperature readout registers
// Assumes: sample and temperature inputs come from logic on SYS_CLK
// Notes: read data appear in the cycle after the read strobe, zero otherwise

`timescale 1ns/1ps
`default_nettype none

module asr_readout (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // sensor core
  input wire logic SAMPLE_VALID,
  input wire asr_pkg::asr_sample_t SAMPLE_DATA,
  input wire asr_pkg::asr_temp_t TEMP_DATA,
  // interrupt
  output logic IRQ
);

  // ==========================================================
  // decode
  function automatic logic [2:0] low_hit(input logic [7:0] a);
    low_hit = {a == asr_pkg::ASR_OFS_Z_LOW, a == asr_pkg::ASR_OFS_Y_LOW,
               a == asr_pkg::ASR_OFS_X_LOW};
  endfunction

  function automatic logic [2:0] high_hit(input logic [7:0] a);
    high_hit = {a == asr_pkg::ASR_OFS_Z_HIGH, a == asr_pkg::ASR_OFS_Y_HIGH,
                a == asr_pkg::ASR_OFS_X_HIGH};
  endfunction

  wire logic [2:0] rd_low = REG_RD ? low_hit(REG_ADDR) : 3'h0;
  wire logic [2:0] rd_high = REG_RD ? high_hit(REG_ADDR) : 3'h0;
  wire logic wr_ctrl = REG_WR && (REG_ADDR == asr_pkg::ASR_OFS_CTRL);
  wire logic wr_status = REG_WR && (REG_ADDR == asr_pkg::ASR_OFS_INT_STATUS);
  wire logic wr_mask = REG_WR && (REG_ADDR == asr_pkg::ASR_OFS_INT_MASK);

  // ==========================================================
  // control
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  wire logic lock_dis = ctrl_reg[asr_pkg::ASR_CTRL_LOCK_DIS_BIT];

  assign ctrl_next = wr_ctrl ? REG_WDATA : ctrl_reg;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= asr_pkg::ASR_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================
  // per-axis sample, shadow, lock and fresh flag
  logic [11:0] live_reg [asr_pkg::ASR_AXES];
  logic [7:0] shadow_reg [asr_pkg::ASR_AXES];
  logic [2:0] lock_reg;
  logic [2:0] fresh_reg;
  logic [2:0] overrun;
  wire logic [11:0] sample_in [asr_pkg::ASR_AXES];

  assign sample_in[0] = SAMPLE_DATA.x;
  assign sample_in[1] = SAMPLE_DATA.y;
  assign sample_in[2] = SAMPLE_DATA.z;

  genvar g;
  generate
    for (g = 0; g < asr_pkg::ASR_AXES; g++) begin : g_axis
      logic [11:0] live_next;
      logic [7:0] shadow_next;
      logic lock_next;
      logic fresh_next;

      assign live_next = SAMPLE_VALID ? sample_in[g] : live_reg[g];
      // the high half is caught in the same cycle as the low half is read
      assign shadow_next = (rd_low[g] && !lock_dis) ?
                           live_reg[g][11:4] : shadow_reg[g];
      // a low read wins over a high read; the port never has both at once
      assign lock_next = (rd_low[g] && !lock_dis) ? 1'b1 :
                         (rd_high[g] ? 1'b0 : lock_reg[g]);
      // a new sample beats a readout in the same cycle
      assign fresh_next = SAMPLE_VALID ? 1'b1 :
                          (rd_high[g] ? 1'b0 : fresh_reg[g]);
      assign overrun[g] = SAMPLE_VALID && lock_reg[g];

      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          live_reg[g] <= asr_pkg::ASR_SAMPLE_RESET;
          shadow_reg[g] <= 8'h00;
          lock_reg[g] <= 1'b0;
          fresh_reg[g] <= 1'b0;
        end else begin
          live_reg[g] <= live_next;
          shadow_reg[g] <= shadow_next;
          lock_reg[g] <= lock_next;
          fresh_reg[g] <= fresh_next;
        end
      end
    end
  endgenerate

  // ==========================================================
  // temperature: input in whole degrees, stored relative to the zero point
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  wire logic signed [8:0] temp_diff =
    9'(signed'(TEMP_DATA.degc)) - asr_pkg::ASR_TEMP_ZERO_9;
  // saturate instead of wrapping, so a cold die never reads as hot
  wire logic [7:0] temp_code =
    (temp_diff > 9'sh07f) ? 8'h7f :
    (temp_diff < -9'sh080) ? 8'h80 : temp_diff[7:0];

  assign temp_next = TEMP_DATA.valid ? temp_code : temp_reg;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      temp_reg <= asr_pkg::ASR_TEMP_RESET;
    end else begin
      temp_reg <= temp_next;
    end
  end

  // ==========================================================
  // interrupt status and mask
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic irq_reg;
  wire logic [2:0] int_event = {|overrun, TEMP_DATA.valid, SAMPLE_VALID};
  wire logic [2:0] int_clear = wr_status ? REG_WDATA[2:0] : 3'h0;

  // set beats a write-one-to-clear in the same cycle
  assign status_next = (status_reg & ~int_clear) | int_event;
  assign mask_next = wr_mask ? REG_WDATA[2:0] : mask_reg;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      status_reg <= 3'h0;
      mask_reg <= asr_pkg::ASR_INT_MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // read mux
  logic [7:0] rdata_reg;
  logic [7:0] rd_mux;

  function automatic logic [7:0] low_byte(input logic [11:0] s,
                                          input logic f);
    // bits 3:1 carry nothing and read as zero
    low_byte = {s[3:0], 3'h0, f};
  endfunction

  wire logic [7:0] high_x = lock_reg[0] ? shadow_reg[0] : live_reg[0][11:4];
  wire logic [7:0] high_y = lock_reg[1] ? shadow_reg[1] : live_reg[1][11:4];
  wire logic [7:0] high_z = lock_reg[2] ? shadow_reg[2] : live_reg[2][11:4];

  always_comb begin
    rd_mux = 8'h00;
    unique case (REG_ADDR)
      asr_pkg::ASR_OFS_X_LOW: begin
        rd_mux = low_byte(live_reg[0], fresh_reg[0]);
      end
      asr_pkg::ASR_OFS_X_HIGH: begin
        rd_mux = high_x;
      end
      asr_pkg::ASR_OFS_Y_LOW: begin
        rd_mux = low_byte(live_reg[1], fresh_reg[1]);
      end
      asr_pkg::ASR_OFS_Y_HIGH: begin
        rd_mux = high_y;
      end
      asr_pkg::ASR_OFS_Z_LOW: begin
        rd_mux = low_byte(live_reg[2], fresh_reg[2]);
      end
      asr_pkg::ASR_OFS_Z_HIGH: begin
        rd_mux = high_z;
      end
      asr_pkg::ASR_OFS_TEMP: begin
        rd_mux = temp_reg;
      end
      asr_pkg::ASR_OFS_CTRL: begin
        rd_mux = ctrl_reg;
      end
      asr_pkg::ASR_OFS_INT_STATUS: begin
        rd_mux = {5'h00, status_reg};
      end
      asr_pkg::ASR_OFS_INT_MASK: begin
        rd_mux = {5'h00, mask_reg};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= REG_RD ? rd_mux : 8'h00;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign IRQ = irq_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  property p_lock_take;
    rd_low[0] && !lock_dis |=> lock_reg[0] &&
      shadow_reg[0] == $past(live_reg[0][11:4]);
  endproperty
  a_lock_take: assert property (p_lock_take)
    else $error("low byte read did not lock the x high byte");

  property p_lock_hold;
    lock_reg[0] && !rd_high[0] && !rd_low[0] |=>
      lock_reg[0] && $stable(shadow_reg[0]);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("x high byte lock dropped before its read");

  property p_high_value;
    rd_high[1] && !lock_reg[1] |=> REG_RDATA == $past(live_reg[1][11:4]);
  endproperty
  a_high_value: assert property (p_high_value)
    else $error("unlocked high byte shows wrong sample bits");

  property p_low_data;
    rd_low[2] |=> REG_RDATA[7:4] == $past(live_reg[2][3:0]);
  endproperty
  a_low_data: assert property (p_low_data)
    else $error("low byte shows wrong sample bits");

  property p_low_undef;
    |rd_low |=> REG_RDATA[3:1] == 3'h0;
  endproperty
  a_low_undef: assert property (p_low_undef)
    else $error("low byte spare bits not zero");

  property p_fresh_set;
    SAMPLE_VALID |=> fresh_reg == 3'h7 ##1 REG_RDATA[0] || !$past(rd_low[0]);
  endproperty
  a_fresh_set: assert property (p_fresh_set)
    else $error("new sample did not set the fresh flags");

  property p_fresh_clear;
    rd_high[1] && !SAMPLE_VALID |=> !fresh_reg[1];
  endproperty
  a_fresh_clear: assert property (p_fresh_clear)
    else $error("high byte read did not clear the fresh flag");

  property p_temp_code;
    TEMP_DATA.valid && TEMP_DATA.degc == 8'sh17 |=> temp_reg == 8'h00;
  endproperty
  a_temp_code: assert property (p_temp_code)
    else $error("23 degrees did not give code zero");

  property p_temp_read;
    REG_RD && REG_ADDR == asr_pkg::ASR_OFS_TEMP |=>
      REG_RDATA == $past(temp_reg);
  endproperty
  a_temp_read: assert property (p_temp_read)
    else $error("temperature readout mismatch");

  property p_x_low_addr;
    REG_RD && REG_ADDR == 8'h02 |=> REG_RDATA[0] == $past(fresh_reg[0]);
  endproperty
  a_x_low_addr: assert property (p_x_low_addr)
    else $error("x low byte at 0x02 shows wrong fresh flag");

  property p_irq;
    |(status_reg & mask_reg) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked status did not raise the interrupt");

  property p_temp_hold;
    !TEMP_DATA.valid |=> $stable(temp_reg);
  endproperty
  a_temp_hold: assert property (p_temp_hold)
    else $error("temperature changed without a new reading");

  property p_high_locked;
    rd_high[0] && lock_reg[0] |=> REG_RDATA == $past(shadow_reg[0]);
  endproperty
  a_high_locked: assert property (p_high_locked)
    else $error("locked x high byte did not show the snapshot");

  property p_lock_release;
    rd_high[2] |=> !lock_reg[2];
  endproperty
  a_lock_release: assert property (p_lock_release)
    else $error("z high byte read did not end the lock");

  property p_lock_dis;
    lock_dis && !lock_reg[2] |=> !lock_reg[2];
  endproperty
  a_lock_dis: assert property (p_lock_dis)
    else $error("z high byte locked although the lock is disabled");

  property p_overrun;
    SAMPLE_VALID && lock_reg[1] && !rd_high[1] && !rd_low[1] |=>
      status_reg[asr_pkg::ASR_INT_OVERRUN_BIT] && $stable(shadow_reg[1]);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("sample during y lock lost the snapshot or the flag");

  property p_status_set;
    SAMPLE_VALID |=> status_reg[asr_pkg::ASR_INT_SAMPLE_BIT];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("new sample did not set its status bit");

  property p_irq_low;
    (status_reg & mask_reg) == 3'h0 |=> !IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt high with no unmasked status bit");

  property p_rdata_idle;
    !REG_RD |=> REG_RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside the read answer cycle");

  property p_fresh_keep;
    !SAMPLE_VALID && !rd_high[0] |=> $stable(fresh_reg[0]);
  endproperty
  a_fresh_keep: assert property (p_fresh_keep)
    else $error("x fresh flag changed with no sample and no readout");

  c_locked_pair: cover property (rd_low[0] && !lock_dis ##[1:8] rd_high[0]);
  c_overrun: cover property (lock_reg[1] && SAMPLE_VALID);
  c_irq: cover property (!IRQ ##1 IRQ);
  c_unlocked: cover property (lock_dis && rd_low[2] ##1 rd_high[2]);

endmodule

`default_nettype wire

// ### dv/asr_core_model.sv
// Purpose: sensor core stand-in feeding axis samples and die temperature
// Assumes: driven from the bench through its tasks, one call at a time
// Notes: data lines are inverted outside the valid pulse, so a design
//   that reads them live instead of capturing them is caught

`timescale 1ns/1ps
`default_nettype none

module asr_core_model (
  // clock
  input wire logic clk,
  // sensor core outputs
  output logic sample_valid,
  output asr_pkg::asr_sample_t sample_data,
  output asr_pkg::asr_temp_t temp_data
);

  initial begin
    sample_valid = 1'b0;
    sample_data = '0;
    temp_data = '0;
  end

  // ==========================================================
  // one pulse per new sample, all three axes at once
  task automatic push_sample(input asr_pkg::asr_sample_t s);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_data <= s;
    @(posedge clk);
    sample_valid <= 1'b0;
    sample_data <= ~s;
  endtask

  // whole degrees c; the block applies the offset
  task automatic push_temp(input logic signed [7:0] d);
    @(posedge clk);
    temp_data <= '{valid: 1'b1, degc: d};
    @(posedge clk);
    temp_data <= '{valid: 1'b0, degc: ~d};
  endtask

endmodule

`default_nettype wire

// ### dv/asr_readout_tb.sv
// Purpose: self-checking bench of the sample readout registers
// Assumes: reads and writes follow the one-cycle strobe port protocol
// Notes: reads are issued back to back, so pairs behave like a burst

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end

module asr_readout_tb;

  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic IRQ;
  logic sample_valid;
  asr_pkg::asr_sample_t sample_data;
  asr_pkg::asr_temp_t temp_data;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] tv [4] = '{8'h17, 8'h16, 8'h80, 8'h7f};
  logic [7:0] te [4] = '{8'h00, 8'hff, 8'h80, 8'h68};

  always #10 SYS_CLK = ~SYS_CLK;

  asr_core_model core (
    .clk(SYS_CLK),
    .sample_valid(sample_valid),
    .sample_data(sample_data),
    .temp_data(temp_data)
  );

  asr_readout dut (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .SAMPLE_VALID(sample_valid),
    .SAMPLE_DATA(sample_data),
    .TEMP_DATA(temp_data),
    .IRQ(IRQ)
  );

  // ==========================================================
  // port tasks
  task automatic summarize();
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask

  // ascending reads with no gap; data checked the cycle after each strobe
  task automatic rd(input logic [7:0] a, input int n,
                    input logic [7:0] e [8]);
    for (int i = 0; i <= n; i++) begin
      @(posedge SYS_CLK);
      REG_RD <= (i < n);
      REG_ADDR <= a + 8'(i);
      #1;
      if (i > 0) begin
        `CHK("read data", e[i-1], REG_RDATA)
      end
    end
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(posedge SYS_CLK);
    #1;
    `CHK("irq", v, IRQ)
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    err_total++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    // unmapped 0x01 and the cleared samples all read zero
    rd(8'h01, 8, '{default: 8'h00});
    core.push_sample(36'h800_123_abc);
    // ascending burst: low byte first, boundary value on z
    rd(8'h02, 6, '{8'hc1, 8'hab, 8'h31, 8'h12, 8'h01, 8'h80, 0, 0});
    rd(8'h02, 1, '{8'hc0, 0, 0, 0, 0, 0, 0, 0});
    core.push_sample(36'h7ff_fed_456);
    // high byte stays on the older sample until it is read
    rd(8'h03, 1, '{8'hab, 0, 0, 0, 0, 0, 0, 0});
    // that read ended the lock, so the newer sample shows now
    rd(8'h03, 1, '{8'h45, 0, 0, 0, 0, 0, 0, 0});
    rd(asr_pkg::ASR_OFS_INT_STATUS, 1, '{8'h05, 0, 0, 0, 0, 0, 0, 0});
    rd(8'h02, 1, '{8'h60, 0, 0, 0, 0, 0, 0, 0});
    rd(8'h04, 1, '{8'hd1, 0, 0, 0, 0, 0, 0, 0});
    // lock disabled: the high byte follows the live sample
    wr(asr_pkg::ASR_OFS_CTRL, 8'h01);
    rd(8'h06, 1, '{8'hf1, 0, 0, 0, 0, 0, 0, 0});
    core.push_sample(36'h000_a5a_000);
    rd(8'h07, 1, '{8'h00, 0, 0, 0, 0, 0, 0, 0});
    wr(asr_pkg::ASR_OFS_CTRL, 8'h00);
    // interrupt: cleared, masked, then raised by a temperature event
    wr(asr_pkg::ASR_OFS_INT_STATUS, 8'h07);
    irq_is(1'b0);
    wr(asr_pkg::ASR_OFS_INT_MASK, 8'h02);
    core.push_sample(36'h111_222_333);
    irq_is(1'b0);
    for (int i = 0; i < 4; i++) begin
      core.push_temp(tv[i]);
      rd(asr_pkg::ASR_OFS_TEMP, 1, '{te[i], 0, 0, 0, 0, 0, 0, 0});
    end
    irq_is(1'b1);
    wr(asr_pkg::ASR_OFS_INT_STATUS, 8'h02);
    irq_is(1'b0);
    summarize();
  end

endmodule

`default_nettype wire
